/* verilog/usart_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - Port enable with both pin direction bits set routes pins to the port.
// - Nine-bit receive select chooses nine-bit or eight-bit characters.
// - Synchronous master single receive takes one character, then clears itself.
// - Single receive has no effect when asynchronous or synchronous slave.
// - Asynchronous continuous receive runs while set, stops while clear.
// - Synchronous continuous receive runs until cleared and overrides single receive.
// - Asynchronous nine-bit address detect loads only characters with bit 8 one.
// - Without address detect every character loads; ninth bit serves as parity.
// - Address detect is ignored in asynchronous eight-bit and synchronous modes.
// - Read-only framing flag follows the character, updated on next valid load.
// - Read-only overrun flag sets on overrun, clears only with continuous receive off.
// - Ninth bit of the last received character reads as a status bit.
// - One 8-bit free-running baud timer serves both modes, period from divisor.
// - High speed select picks the asynchronous divide factor.
// - High speed select is ignored in synchronous mode.
// - Baud generator runs in asynchronous mode and for synchronous master; synchronous slave clock is external.
// - Rate is clock over 64, 16 or 4 times divisor plus one.
// - Writing the divisor clears the baud timer at once.
module usart_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire usart_pkg::bus_req_s i_bus,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_pin_direction_bits,
  input wire usart_pkg::rx_char_s i_rx_char,
  input wire logic i_tx_shift_busy,
  output usart_pkg::ctrl_s o_ctrl,
  output logic o_rx_load,
  output logic o_baud_tick
);

  logic [7:0] rcv_q;
  logic [7:0] xmt_q;
  logic [7:0] divisor_q;
  logic [7:0] rcv_buf_q;
  logic buf_full_q;
  logic framing_error_flag_q;
  logic overrun_error_flag_q;
  logic received_ninth_bit_q;
  logic shift_empty_flag_q;
  logic [7:0] read_mux_t;
  logic wr_rcv;
  logic wr_xmt;
  logic wr_div;
  logic rd_buf;
  logic port_enable;
  logic sync_mode;
  logic master_mode;
  logic rx_run;
  logic accept;
  logic char_in;
  logic overrun_event;

  assign wr_rcv = i_bus.wr && (i_bus.addr == usart_pkg::RCV_CTRL_ADDR);
  assign wr_xmt = i_bus.wr && (i_bus.addr == usart_pkg::XMT_CTRL_ADDR);
  assign wr_div = i_bus.wr && (i_bus.addr == usart_pkg::DIVISOR_ADDR);
  assign rd_buf = i_bus.rd && (i_bus.addr == usart_pkg::RCV_BUF_ADDR);

  assign port_enable = rcv_q[usart_pkg::RC_PORT_EN];
  assign sync_mode = xmt_q[usart_pkg::TX_SYNC];
  assign master_mode = xmt_q[usart_pkg::TX_CLK_SRC];

  // Receiver run: continuous wins, single only counts for synchronous master
  // single ignored
  assign rx_run = port_enable && (sync_mode ?
                  (rcv_q[usart_pkg::RC_CONT] || (master_mode && rcv_q[usart_pkg::RC_SINGLE])) :
                  rcv_q[usart_pkg::RC_CONT]);

  // Address filter only applies to asynchronous nine-bit reception
  // address filter
  assign accept = sync_mode || !rcv_q[usart_pkg::RC_NINE] ||
                  !rcv_q[usart_pkg::RC_ADDR_DET] || i_rx_char.data[8];

  assign char_in = i_rx_char.done && rx_run && accept;
  // A full, unread buffer means the character has nowhere to go
  assign overrun_event = char_in && buf_full_q && !rd_buf;
  assign o_rx_load = char_in && !overrun_event && !overrun_error_flag_q;

  // Outputs towards the shift datapaths and the pins
  always_comb begin
    o_ctrl.port_active = port_enable && (i_pin_direction_bits == 2'b11);
    o_ctrl.rx_run = rx_run;
    o_ctrl.rx_nine = rcv_q[usart_pkg::RC_NINE];
    o_ctrl.tx_nine = xmt_q[usart_pkg::TX_NINE];
    o_ctrl.tx_enable = xmt_q[usart_pkg::TX_EN];
    o_ctrl.sync = sync_mode;
    o_ctrl.master = master_mode;
    o_ctrl.tx_ninth = xmt_q[usart_pkg::TX_NINTH];
  end

  // Receive control bits; a software write beats the hardware self-clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rcv_q <= usart_pkg::RCV_CTRL_RESET;
    end else if (wr_rcv) begin
      rcv_q <= i_bus.wdata & usart_pkg::RCV_WR_MASK;
    end else if (sync_mode && master_mode && !rcv_q[usart_pkg::RC_CONT] &&
                 i_rx_char.done && rx_run) begin
      rcv_q[usart_pkg::RC_SINGLE] <= 1'b0;
    end
  end

  // Transmit control bits, status bits are held apart
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      xmt_q <= usart_pkg::XMT_CTRL_RESET & usart_pkg::XMT_WR_MASK;
    end else if (wr_xmt) begin
      xmt_q <= i_bus.wdata & usart_pkg::XMT_WR_MASK;
    end
  end

  // Divisor register; its write also clears the baud timer
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      divisor_q <= usart_pkg::DIVISOR_RESET;
    end else if (wr_div) begin
      divisor_q <= i_bus.wdata;
    end
  end

  // Receive buffer and its character status
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rcv_buf_q <= 8'h00;
      framing_error_flag_q <= 1'b0;
      received_ninth_bit_q <= 1'b0;
    end else if (o_rx_load) begin
      rcv_buf_q <= i_rx_char.data[7:0];
      framing_error_flag_q <= i_rx_char.frame_err;
      received_ninth_bit_q <= i_rx_char.data[8];
    end
  end

  // Buffer occupancy: a load in the cycle of a read keeps it full
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      buf_full_q <= 1'b0;
    end else if (o_rx_load) begin
      buf_full_q <= 1'b1;
    end else if (rd_buf) begin
      buf_full_q <= 1'b0;
    end
  end

  // Overrun sticks while continuous receive stays on; set wins over clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      overrun_error_flag_q <= 1'b0;
    end else if (overrun_event) begin
      overrun_error_flag_q <= 1'b1;
    end else if (!rcv_q[usart_pkg::RC_CONT]) begin
      overrun_error_flag_q <= 1'b0;
    end
  end

  // Shift-empty status, registered from the transmit datapath
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      shift_empty_flag_q <= usart_pkg::XMT_CTRL_RESET[usart_pkg::TX_EMPTY];
    end else begin
      shift_empty_flag_q <= !i_tx_shift_busy;
    end
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    read_mux_t = 8'h00;
    case (i_bus.addr)
      usart_pkg::RCV_CTRL_ADDR: begin
        read_mux_t = rcv_q;
        read_mux_t[usart_pkg::RC_FRAME] = framing_error_flag_q;
        read_mux_t[usart_pkg::RC_OVERRUN] = overrun_error_flag_q;
        read_mux_t[usart_pkg::RC_NINTH] = received_ninth_bit_q;
      end
      usart_pkg::XMT_CTRL_ADDR: begin
        read_mux_t = xmt_q;
        read_mux_t[usart_pkg::TX_EMPTY] = shift_empty_flag_q;
      end
      usart_pkg::DIVISOR_ADDR: begin
        read_mux_t = divisor_q;
      end
      usart_pkg::RCV_BUF_ADDR: begin
        read_mux_t = rcv_buf_q;
      end
      default: begin
        read_mux_t = 8'h00;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_bus.rd ? read_mux_t : 8'h00;
    end
  end

  // Baud generator, enabled only when this end makes the bit clock
  // shared baud timer
  usart_baud_gen baud_generator (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_enable(port_enable && (!sync_mode || master_mode)),
    .i_sync(sync_mode),
    .i_high_speed(xmt_q[usart_pkg::TX_HIGH_SPEED]),
    .i_divisor(divisor_q),
    .i_clear(wr_div),
    .o_tick(o_baud_tick)
  );

  // Checked from the bus side so a broken enable register is caught too
  port_route_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_rcv |=> o_ctrl.port_active ==
    ($past(i_bus.wdata[usart_pkg::RC_PORT_EN]) && (i_pin_direction_bits == 2'b11)))
    else $error("port routing does not follow enable and directions");

  single_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (sync_mode && master_mode && !rcv_q[usart_pkg::RC_CONT] && i_rx_char.done &&
    rx_run && !wr_rcv) |=> !rcv_q[usart_pkg::RC_SINGLE])
    else $error("single receive not cleared after character");

  single_ignored_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!rcv_q[usart_pkg::RC_CONT] && (!sync_mode || !master_mode)) |-> !rx_run)
    else $error("single receive active outside synchronous master");

  cont_run_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (port_enable && rcv_q[usart_pkg::RC_CONT]) |-> rx_run)
    else $error("continuous receive not running");

  addr_filter_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!sync_mode && rcv_q[usart_pkg::RC_NINE] && rcv_q[usart_pkg::RC_ADDR_DET] &&
    !i_rx_char.data[8]) |-> !o_rx_load)
    else $error("non-address character loaded");

  accept_all_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_rx_char.done && rx_run && !buf_full_q && !overrun_error_flag_q &&
    (sync_mode || !rcv_q[usart_pkg::RC_NINE])) |-> o_rx_load)
    else $error("character dropped by ignored address detect");

  overrun_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (overrun_error_flag_q && rcv_q[usart_pkg::RC_CONT]) |=> overrun_error_flag_q)
    else $error("overrun flag cleared while continuous receive on");

  frame_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_rx_load |=> framing_error_flag_q == $past(i_rx_char.frame_err) &&
    received_ninth_bit_q == $past(i_rx_char.data[8]))
    else $error("character status not captured on load");

  empty_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_tx_shift_busy |=> !shift_empty_flag_q ##1 (shift_empty_flag_q == !$past(i_tx_shift_busy)))
    else $error("shift empty flag wrong");

  cont_async_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!sync_mode && !rcv_q[usart_pkg::RC_CONT]) |-> !rx_run)
    else $error("asynchronous receive running with continuous receive off");

  overrun_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (char_in && buf_full_q && !rd_buf) |=> overrun_error_flag_q && !$past(o_rx_load))
    else $error("overrun not flagged on full buffer");

  buf_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_rx_load |=> buf_full_q && rcv_buf_q == $past(i_rx_char.data[7:0]))
    else $error("accepted character not placed in receive buffer");

endmodule

/* verilog/usart_pkg.sv */
package usart_pkg;

  // Register addresses on the plain register port
  localparam logic [7:0] RCV_CTRL_ADDR = 8'h18;
  localparam logic [7:0] XMT_CTRL_ADDR = 8'h98;
  localparam logic [7:0] DIVISOR_ADDR = 8'h99;
  localparam logic [7:0] RCV_BUF_ADDR = 8'h1A;

  // Field positions of receive_status_control
  localparam int RC_PORT_EN = 7;
  localparam int RC_NINE = 6;
  localparam int RC_SINGLE = 5;
  localparam int RC_CONT = 4;
  localparam int RC_ADDR_DET = 3;
  localparam int RC_FRAME = 2;
  localparam int RC_OVERRUN = 1;
  localparam int RC_NINTH = 0;

  // Field positions of transmit_status_control
  localparam int TX_CLK_SRC = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_HIGH_SPEED = 2;
  localparam int TX_EMPTY = 1;
  localparam int TX_NINTH = 0;

  // Reset values and software-writable masks
  localparam logic [7:0] RCV_CTRL_RESET = 8'h00;
  localparam logic [7:0] XMT_CTRL_RESET = 8'h02;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic [7:0] RCV_WR_MASK = 8'hF8;
  localparam logic [7:0] XMT_WR_MASK = 8'hF5;

  // Divide factors applied in front of the divisor
  localparam logic [6:0] DIV_ASYNC_LOW = 7'h40;
  localparam logic [6:0] DIV_ASYNC_HIGH = 7'h10;
  localparam logic [6:0] DIV_SYNC = 7'h04;

  // One register port access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // One character handed over by the receive shift datapath
  typedef struct packed {
    logic done;
    logic frame_err;
    logic [8:0] data;
  } rx_char_s;

  // Settings driven out to the shift datapaths and pins
  typedef struct packed {
    logic port_active;
    logic rx_run;
    logic rx_nine;
    logic tx_nine;
    logic tx_enable;
    logic sync;
    logic master;
    logic tx_ninth;
  } ctrl_s;

endpackage

/* verilog/usart_baud_gen.sv */
`timescale 1ns/1ps
module usart_baud_gen (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_sync,
  input wire logic i_high_speed,
  input wire logic [7:0] i_divisor,
  input wire logic i_clear,
  output logic o_tick
);

  logic [6:0] factor_t;
  logic [6:0] pre_q;
  logic [7:0] timer_q;
  logic pre_end;
  logic [3:0] since_clear_q;

  // Divide factor: high speed only matters when asynchronous
  always_comb begin
    if (i_sync) begin
      factor_t = usart_pkg::DIV_SYNC;
    end else if (i_high_speed) begin
      factor_t = usart_pkg::DIV_ASYNC_HIGH;
    end else begin
      factor_t = usart_pkg::DIV_ASYNC_LOW;
    end
  end

  assign pre_end = (pre_q == factor_t - 7'h01);

  // Prescaler and free-running 8-bit timer, both cleared on a divisor write
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || i_clear || !i_enable) begin
      pre_q <= 7'h00;
      timer_q <= 8'h00;
    end else if (pre_end) begin
      pre_q <= 7'h00;
      timer_q <= (timer_q == i_divisor) ? 8'h00 : timer_q + 8'h01;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // One-cycle tick per factor*(divisor+1) cycles
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_enable && !i_clear && pre_end && (timer_q == i_divisor);
    end
  end

  // Cycles since the last clear, saturating, for checking only
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || i_clear) begin
      since_clear_q <= 4'h0;
    end else if (since_clear_q != 4'hF) begin
      since_clear_q <= since_clear_q + 4'h1;
    end
  end

  clear_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_tick |-> since_clear_q >= 4'h3)
    else $error("baud tick too soon after divisor write");

  tick_master_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_tick |-> $past(i_enable))
    else $error("baud tick while generator disabled");

  // A tick leaves prescaler and timer at zero, so the next one follows four cycles on
  sync_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_tick && i_sync && i_divisor == 8'h00 && i_enable && !i_clear) ##1
    (i_sync && i_divisor == 8'h00 && i_enable && !i_clear)[*3] |=> o_tick)
    else $error("synchronous rate with divisor zero not clock/4");

endmodule

/* bench/rx_side_model.sv */
`timescale 1ns/1ps
// Stands in for the shift datapaths: one character per request, busy passed through
module rx_side_model (
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic [8:0] i_data,
  input wire logic i_framing_error_flag,
  input wire logic i_busy,
  output usart_pkg::rx_char_s o_char,
  output logic o_busy
);
  logic [8:0] last_q = 9'h000;

  // Remember the last character so idle lines can show something else
  always_ff @(posedge i_clk_sys) begin
    if (i_go) begin
      last_q <= i_data;
    end
  end

  // Outside a handover the lines carry the inverse, so stale data is never mistaken
  assign o_char.done = i_go;
  assign o_char.frame_err = i_go ? i_framing_error_flag : ~last_q[0];
  assign o_char.data = i_go ? i_data : ~last_q;
  assign o_busy = i_busy;
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys;
  logic i_rst_n;
  usart_pkg::bus_req_s bus;
  logic [1:0] pins;
  logic go;
  logic [8:0] cd;
  logic cf;
  logic busy;
  usart_pkg::rx_char_s rx_char;
  logic tx_busy;
  logic [7:0] rdata;
  usart_pkg::ctrl_s ctrl;
  logic load;
  logic tick;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;

  usart_ctrl i_dut (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_bus(bus),
    .o_rdata(rdata),
    .i_pin_direction_bits(pins),
    .i_rx_char(rx_char),
    .i_tx_shift_busy(tx_busy),
    .o_ctrl(ctrl),
    .o_rx_load(load),
    .o_baud_tick(tick)
  );

  rx_side_model i_far (
    .i_clk_sys(i_clk_sys),
    .i_go(go),
    .i_data(cd),
    .i_framing_error_flag(cf),
    .i_busy(busy),
    .o_char(rx_char),
    .o_busy(tx_busy)
  );

  // Free-running 50 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cut a hang short; the longest baud case needs about 8500 cycles
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_clk_sys);
    bus.wr <= 1'b0;
    // Let the written register settle before anyone looks at the outputs
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so look there
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clk_sys);
    bus.rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask

  // Load strobe is combinational, judged in the cycle of the handover
  task automatic send(input logic [8:0] d, input logic f, input logic el);
    @(posedge i_clk_sys);
    go <= 1'b1;
    cd <= d;
    cf <= f;
    #1;
    check("load", load, el);
    @(posedge i_clk_sys);
    go <= 1'b0;
  endtask

  task automatic t_regs();
    rd("rcv reset", 8'h18, 8'h00);
    rd("xmt reset", 8'h98, 8'h02);
    rd("div reset", 8'h99, 8'h00);
    rd("unmapped", 8'h55, 8'h00);
    check("ctrl reset", ctrl, 8'h00);
    wr(8'h18, 8'hFF);
    rd("rcv ro bits", 8'h18, 8'hF8);
    wr(8'h98, 8'hFF);
    rd("xmt ro bits", 8'h98, 8'hF7);
    check("ctrl all", ctrl, 8'hFF);
    @(posedge i_clk_sys);
    pins <= 2'b10;
    @(posedge i_clk_sys);
    #1;
    check("one pin off", ctrl.port_active, 1'b0);
    @(posedge i_clk_sys);
    pins <= 2'b11;
    busy <= 1'b1;
    rd("shift full", 8'h98, 8'hF5);
    @(posedge i_clk_sys);
    busy <= 1'b0;
    wr(8'h98, 8'h41);
    check("ctrl mix", ctrl, 8'hF1);
    rd("shift empty", 8'h98, 8'h43);
    wr(8'h18, 8'h00);
    wr(8'h98, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_async();
    wr(8'h18, 8'hD0);
    check("rx nine", ctrl.rx_nine, 1'b1);
    send(9'h141, 1'b1, 1'b1);
    rd("flags", 8'h18, 8'hD5);
    rd("buffer", 8'h1A, 8'h41);
    wr(8'h18, 8'hC0);
    send(9'h0AA, 1'b0, 1'b0);
    wr(8'h18, 8'h90);
    send(9'h033, 1'b0, 1'b1);
    send(9'h034, 1'b0, 1'b0);
    rd("overrun set", 8'h18, 8'h92);
    wr(8'h18, 8'h80);
    rd("overrun clear", 8'h18, 8'h80);
    rd("kept char", 8'h1A, 8'h33);
    $display("test async receive done");
  endtask

  task automatic t_addr();
    wr(8'h18, 8'hD8);
    send(9'h055, 1'b0, 1'b0);
    send(9'h1AA, 1'b0, 1'b1);
    rd("addr char", 8'h1A, 8'hAA);
    wr(8'h18, 8'h98);
    send(9'h055, 1'b0, 1'b1);
    rd("eight bit", 8'h1A, 8'h55);
    wr(8'h18, 8'hD0);
    send(9'h0CC, 1'b0, 1'b1);
    rd("parity bit", 8'h18, 8'hD0);
    rd("all chars", 8'h1A, 8'hCC);
    wr(8'h98, 8'h90);
    wr(8'h18, 8'hD8);
    send(9'h066, 1'b0, 1'b1);
    rd("sync char", 8'h1A, 8'h66);
    $display("test address detect done");
  endtask

  task automatic t_sync();
    wr(8'h18, 8'hA0);
    check("single run", ctrl.rx_run, 1'b1);
    send(9'h012, 1'b0, 1'b1);
    rd("single clear", 8'h18, 8'h80);
    rd("single char", 8'h1A, 8'h12);
    wr(8'h18, 8'hB0);
    send(9'h013, 1'b0, 1'b1);
    rd("cont wins", 8'h18, 8'hB0);
    rd("cont char", 8'h1A, 8'h13);
    wr(8'h18, 8'h00);
    wr(8'h98, 8'h00);
    wr(8'h18, 8'hA0);
    send(9'h014, 1'b0, 1'b0);
    wr(8'h98, 8'h10);
    send(9'h015, 1'b0, 1'b0);
    rd("single kept", 8'h18, 8'hA0);
    $display("test sync receive done");
  endtask

  // Period in cycles between ticks; zero means no tick is allowed
  task automatic baud(input logic [7:0] x, input logic [7:0] dv, input int n);
    int c;
    int k;
    wr(8'h18, 8'h80);
    wr(8'h98, x);
    wr(8'h99, dv);
    c = 0;
    k = 0;
    repeat (2 * n + 300) begin
      @(posedge i_clk_sys);
      #1;
      c++;
      if (tick === 1'b1) begin
        k++;
        if (k == 1) check("first tick", 16'(c), 16'(n));
        if (k == 2) check("tick period", 16'(c), 16'(n));
        c = 0;
      end
    end
    if (n == 0) check("slave ticks", 16'(k), 16'h0000);
    else check("tick count", 16'(k), 16'((2 * n + 300) / n));
    rd("divisor", 8'h99, dv);
    $display("test baud %h %h done", x, dv);
  endtask

  initial begin
    i_rst_n = 1'b0;
    bus = '0;
    pins = 2'b11;
    go = 1'b0;
    cd = 9'h000;
    cf = 1'b0;
    busy = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_regs();
    t_async();
    t_addr();
    t_sync();
    baud(8'h00, 8'h02, 192);
    baud(8'h04, 8'h01, 32);
    baud(8'h90, 8'h03, 16);
    baud(8'h90, 8'h00, 4);
    baud(8'h94, 8'h03, 16);
    baud(8'h04, 8'hFF, 4096);
    baud(8'h10, 8'h03, 0);
    give_verdict();
  end
endmodule
